// *** scc_regs.svh ***
// register offsets, field positions and array geometry of the split cache
`ifndef SCC_REGS_SVH
`define SCC_REGS_SVH

// ----------------------------------------------------------------------
// apb register byte offsets
// ----------------------------------------------------------------------
`define SCC_OFS_CTRL     8'h00
`define SCC_OFS_PERR     8'h04
`define SCC_OFS_FAULT    8'h08
`define SCC_OFS_STAT     8'h0C

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define SCC_CTRL_INJECT  0
`define SCC_CTRL_TRAPOFF 1
`define SCC_FLT_ITAG     0
`define SCC_FLT_IDATA    1
`define SCC_FLT_DTAG     2
`define SCC_FLT_DDATA    3
`define SCC_FLT_MEM      4
`define SCC_TAG_VALID    22
`define SCC_TAG_PAR      23
`define SCC_TAG_DIRTY    24
`define SCC_TAG_DPAR     25

// ----------------------------------------------------------------------
// geometry and reset values
// ----------------------------------------------------------------------
`define SCC_LINE_WORDS   3'h4
`define SCC_CTRL_RST     2'h0
`define SCC_PERR_RST     4'h0
`define SCC_FAULT_RST    5'h00

`endif

// *** scc_pkg.sv ***
// types and parity helpers shared by the split cache controller
package scc_pkg;

	// controller sequencer, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WB   = 3'b010,
		ST_FILL = 3'b100
	} scc_state_t;

	// core request kinds
	typedef enum logic [2:0] {
		OP_LOAD   = 3'h0,
		OP_STORE  = 3'h1,
		OP_IFETCH = 3'h2,
		OP_DWBINV = 3'h3,
		OP_IINV   = 3'h4
	} scc_op_t;

	// even parity per byte of a word
	function automatic logic [3:0] scc_bpar(input logic [31:0] w);
		logic [3:0] p;
		p = 4'h0;
		for (int b = 0; b < 4; b++) begin
			p[b] = ^w[b*8 +: 8];
		end
		return p;
	endfunction

endpackage

// *** scc_top.sv ***
// split instruction/data cache controller with apb control registers
//
// Overview of operation
// RULE1: cache hit answers in one clock
// RULE2: stores pipelined: tag check, then data write
// RULE3: lines are four 32-bit words, one tag
// RULE4: instruction cache 2 KB, data cache 1 KB
// RULE5: itag: label, valid, even label parity
// RULE6: one even parity bit per instruction word
// RULE7: icache direct-mapped, virtual index, physical tag
// RULE8: dtag adds dirty flag and its parity
// RULE9: dcache write-back, direct-mapped, virtual index, physical tag
// RULE10: dcache index va 9:4, icache va 10:4
// RULE11: hit returns data, miss refills whole line
// RULE12: dirty line written only on replace or maintenance
// RULE13: line invalid after being written back
// RULE14: dcache invalid/clean/dirty, icache invalid/valid
// RULE15: refill and first write change state only
// RULE16: parity checked on reads, errors raise exception
// RULE17: fault report names the detecting source
// RULE18: write-back passes data and address parity
// RULE19: write-back data error still completes
// RULE20: write-back tag error issues no bus cycle
// RULE21: maintenance tag error aborts the operation
// RULE22: no outside port into cache arrays
// RULE23: inject mode writes parity register into arrays; code injects only on stores and icache refills, not dcache refills or tags
// RULE24: trap-off mode suppresses parity exceptions
// RULE25: clean or invalid victim goes straight to refill
`timescale 1ns/100ps
`include "scc_regs.svh"

module scc_top (
	input  wire logic           pclk,
	input  wire logic           presetn,
	input  wire logic           psel,
	input  wire logic           penable,
	input  wire logic           pwrite,
	input  wire logic [7:0]     paddr,
	input  wire logic [31:0]    pwdata,
	output logic      [31:0]    prdata,
	output logic                pready,
	output logic                pslverr,
	input  wire logic           core_req,
	input  wire scc_pkg::scc_op_t core_op,
	input  wire logic [31:0]    core_vaddr,
	input  wire logic [31:0]    core_paddr,
	input  wire logic [31:0]    core_wdata,
	input  wire logic [3:0]     core_be,
	output logic                core_busy,
	output logic                rsp_valid,
	output logic      [31:0]    rsp_data,
	output logic                cache_err_exc,
	output logic                mem_req,
	output logic                mem_we,
	output logic      [31:0]    mem_addr,
	output logic      [3:0]     mem_apar,
	output logic      [31:0]    mem_wdata,
	output logic      [3:0]     mem_wpar,
	input  wire logic           mem_ack,
	input  wire logic [31:0]    mem_rdata,
	input  wire logic [3:0]     mem_rpar
);
	import scc_pkg::*;

	// ------------------------------------------------------------------
	// storage: flops, not reset; software invalidates first
	// ------------------------------------------------------------------
	logic [25:0] dtag_mem  [0:63];       // RULE4 RULE8 64 lines x 16 B
	logic [31:0] ddata_mem [0:63][0:3];  // RULE3
	logic [3:0]  dpar_mem  [0:63][0:3];  // byte parity per word
	logic [23:0] itag_mem  [0:127];      // RULE4 RULE5 128 lines x 16 B
	logic [31:0] idata_mem [0:127][0:3];
	logic        ipar_mem  [0:127][0:3]; // RULE6

	// ------------------------------------------------------------------
	// control state
	// ------------------------------------------------------------------
	scc_state_t  state_reg;              // sequencer
	logic [1:0]  ctrl_reg;               // inject, trap-off
	logic [3:0]  perr_reg;               // parity values for injection
	logic [4:0]  fault_reg;              // sticky error sources
	logic        pend_reg;               // captured request to finish
	scc_op_t     cap_op_reg;             // captured request
	logic [31:0] cap_va_reg;
	logic [31:0] cap_pa_reg;
	logic [31:0] cap_wd_reg;
	logic [3:0]  cap_be_reg;
	logic [21:0] wb_tag_reg;             // victim label for write-back
	logic [2:0]  wcnt_reg;               // words launched on the bus
	logic        st_v_reg;               // store in data-write stage
	logic [5:0]  st_idx_reg;
	logic [1:0]  st_w_reg;
	logic [31:0] st_d_reg;
	logic [3:0]  st_be_reg;

	// ------------------------------------------------------------------
	// lookup of the active request
	// ------------------------------------------------------------------
	scc_op_t     c_op;                   // active request fields
	logic [31:0] c_va;
	logic [31:0] c_pa;
	logic [31:0] c_wd;
	logic [3:0]  c_be;
	logic        act;                    // a lookup happens this cycle
	logic [5:0]  d_idx;
	logic [6:0]  i_idx;
	logic [1:0]  wsel;
	logic [25:0] dt;
	logic [23:0] it;
	logic        d_tperr;
	logic        i_tperr;
	logic        d_hit;
	logic        i_hit;
	logic        d_dirty;
	logic        st_same;
	logic [31:0] dw;
	logic [3:0]  dp;
	logic        d_dperr;
	logic        i_dperr;

	assign act  = (state_reg == ST_IDLE) && (pend_reg ||
	              (core_req && !core_busy));
	assign c_op = pend_reg ? cap_op_reg : core_op;
	assign c_va = pend_reg ? cap_va_reg : core_vaddr;
	assign c_pa = pend_reg ? cap_pa_reg : core_paddr;
	assign c_wd = pend_reg ? cap_wd_reg : core_wdata;
	assign c_be = pend_reg ? cap_be_reg : core_be;

	assign d_idx = c_va[9:4];                               // RULE10
	assign i_idx = c_va[10:4];                              // RULE10
	assign wsel  = c_va[3:2];
	assign dt    = dtag_mem[d_idx];
	assign it    = itag_mem[i_idx];

	// tag parity covers the label; dirty flag has its own check bit
	assign d_tperr = ((^dt[21:0]) != dt[`SCC_TAG_PAR]) ||
	                 (dt[`SCC_TAG_DIRTY] != dt[`SCC_TAG_DPAR]); // RULE16
	assign i_tperr = (^it[21:0]) != it[`SCC_TAG_PAR];          // RULE16
	// physical label compare on a virtually indexed line
	assign d_hit = dt[`SCC_TAG_VALID] && !d_tperr &&
	               (dt[21:0] == c_pa[31:10]);                  // RULE9
	assign i_hit = it[`SCC_TAG_VALID] && !i_tperr &&
	               (it[21:0] == c_pa[31:10]);                  // RULE7
	// a store in its write stage already dirties the line
	assign st_same = st_v_reg && (st_idx_reg == d_idx);
	assign d_dirty = dt[`SCC_TAG_DIRTY] || st_same;

	// forward bytes of the store in flight to loads
	always_comb begin
		dw = ddata_mem[d_idx][wsel];
		dp = dpar_mem[d_idx][wsel];
		for (int b = 0; b < 4; b++) begin
			if (st_same && (st_w_reg == wsel) && st_be_reg[b]) begin
				dw[b*8 +: 8] = st_d_reg[b*8 +: 8];
				dp[b]        = (ctrl_reg[`SCC_CTRL_INJECT]) ?
				               perr_reg[b] : ^st_d_reg[b*8 +: 8];
			end
		end
	end
	assign d_dperr = scc_bpar(dw) != dp;                        // RULE16
	assign i_dperr = (^idata_mem[i_idx][wsel]) !=
	                 ipar_mem[i_idx][wsel];                     // RULE16

	// ------------------------------------------------------------------
	// bus-cycle helpers
	// ------------------------------------------------------------------
	logic        launch;                 // put next word on the bus
	logic        last_ack;               // final word of the line taken
	logic [1:0]  lw;                     // word being launched
	logic [1:0]  fw;                     // word returned by memory
	logic [5:0]  cap_didx;
	logic [6:0]  cap_iidx;
	logic        cap_is_i;
	logic [31:0] wb_word;
	logic [3:0]  wb_par;
	logic [31:0] fill_addr;
	logic [31:0] wb_addr;

	assign launch   = (!mem_req && (wcnt_reg == 3'h0)) ||
	                  (mem_ack && (wcnt_reg != `SCC_LINE_WORDS));
	assign last_ack = mem_ack && (wcnt_reg == `SCC_LINE_WORDS);
	assign lw       = wcnt_reg[1:0];
	assign fw       = 2'(wcnt_reg - 3'h1);
	assign cap_didx = cap_va_reg[9:4];
	assign cap_iidx = cap_va_reg[10:4];
	assign cap_is_i = (cap_op_reg == OP_IFETCH);
	assign wb_word  = ddata_mem[cap_didx][lw];
	assign wb_par   = dpar_mem[cap_didx][lw];
	assign wb_addr  = {wb_tag_reg, cap_didx, lw, 2'h0};
	assign fill_addr = cap_is_i ? {cap_pa_reg[31:10], cap_iidx[5:0],
	                   lw, 2'h0} : {cap_pa_reg[31:10], cap_didx, lw, 2'h0};

	// ------------------------------------------------------------------
	// error sources seen this cycle
	// ------------------------------------------------------------------
	logic [4:0]  fault_set;
	logic        is_i;

	assign is_i = (c_op == OP_IFETCH) || (c_op == OP_IINV);

	always_comb begin
		fault_set = 5'h00;
		if (act) begin
			// tag checked on every lookup
			if (is_i && i_tperr)
				fault_set[`SCC_FLT_ITAG] = 1'b1;           // RULE17
			if (!is_i && d_tperr)
				fault_set[`SCC_FLT_DTAG] = 1'b1;           // RULE17
			// data checked when delivered
			if ((c_op == OP_IFETCH) && i_hit && i_dperr)
				fault_set[`SCC_FLT_IDATA] = 1'b1;          // RULE17
			if ((c_op == OP_LOAD) && d_hit && d_dperr)
				fault_set[`SCC_FLT_DDATA] = 1'b1;          // RULE17
		end
		// outgoing victim word checked, still written out
		if ((state_reg == ST_WB) && launch &&
		    (scc_bpar(wb_word) != wb_par))
			fault_set[`SCC_FLT_DDATA] = 1'b1;                  // RULE19
		// memory read data checked per byte
		if ((state_reg == ST_FILL) && mem_ack &&
		    (scc_bpar(mem_rdata) != mem_rpar))
			fault_set[`SCC_FLT_MEM] = 1'b1;                    // RULE16
	end

	// exception pulse unless traps are off
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			cache_err_exc <= 1'b0;
		else
			cache_err_exc <= (|fault_set) &&
			                 !ctrl_reg[`SCC_CTRL_TRAPOFF];     // RULE24
	end

	// ------------------------------------------------------------------
	// sequencer: lookup, write-back, refill, replay
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_reg  <= ST_IDLE;
			pend_reg   <= 1'b0;
			core_busy  <= 1'b0;
			rsp_valid  <= 1'b0;
			rsp_data   <= 32'h0000_0000;
			cap_op_reg <= OP_LOAD;
			cap_va_reg <= 32'h0000_0000;
			cap_pa_reg <= 32'h0000_0000;
			cap_wd_reg <= 32'h0000_0000;
			cap_be_reg <= 4'h0;
			wb_tag_reg <= 22'h00_0000;
			wcnt_reg   <= 3'h0;
			mem_req    <= 1'b0;
			mem_we     <= 1'b0;
			mem_addr   <= 32'h0000_0000;
			mem_apar   <= 4'h0;
			mem_wdata  <= 32'h0000_0000;
			mem_wpar   <= 4'h0;
		end else begin
			rsp_valid <= 1'b0;
			case (state_reg)
			ST_IDLE: begin
				if (act) begin
					// keep the request for replay after a miss
					cap_op_reg <= c_op;
					cap_va_reg <= c_va;
					cap_pa_reg <= c_pa;
					cap_wd_reg <= c_wd;
					cap_be_reg <= c_be;
					wcnt_reg   <= 3'h0;
					wb_tag_reg <= dt[21:0];
					case (c_op)
					OP_IFETCH: begin
						if (i_hit) begin                   // RULE1 RULE11
							rsp_valid <= 1'b1;
							rsp_data  <= idata_mem[i_idx][wsel];
							pend_reg  <= 1'b0;
							core_busy <= 1'b0;
						end else begin                     // RULE11
							pend_reg  <= 1'b1;
							core_busy <= 1'b1;
							state_reg <= ST_FILL;
						end
					end
					OP_IINV: begin
						// tag fault aborts; otherwise the line is dropped
						rsp_valid <= 1'b1;                 // RULE21
						pend_reg  <= 1'b0;
						core_busy <= 1'b0;
					end
					OP_DWBINV: begin
						if (!d_tperr && dt[`SCC_TAG_VALID] && d_dirty) begin
							pend_reg  <= 1'b1;             // RULE12
							core_busy <= 1'b1;
							state_reg <= ST_WB;
						end else begin                     // RULE21
							rsp_valid <= 1'b1;
							pend_reg  <= 1'b0;
							core_busy <= 1'b0;
						end
					end
					default: begin
						if (d_hit) begin                   // RULE1 RULE2
							rsp_valid <= 1'b1;
							rsp_data  <= (c_op == OP_LOAD) ? dw : 32'h0;
							pend_reg  <= 1'b0;
							core_busy <= 1'b0;
						end else begin
							pend_reg  <= 1'b1;
							core_busy <= 1'b1;
							// tag fault: victim abandoned, no write-back cycle, straight to refill
							if (!d_tperr && dt[`SCC_TAG_VALID] && d_dirty)
								state_reg <= ST_WB;        // RULE12 RULE20
							else
								state_reg <= ST_FILL;      // RULE25
						end
					end
					endcase
				end
			end
			ST_WB: begin
				if (launch) begin                          // RULE18
					mem_req   <= 1'b1;
					mem_we    <= 1'b1;
					mem_addr  <= wb_addr;
					mem_apar  <= scc_bpar(wb_addr);        // RULE18
					mem_wdata <= wb_word;
					mem_wpar  <= wb_par;                   // RULE18
					wcnt_reg  <= wcnt_reg + 3'h1;
				end else if (last_ack) begin
					mem_req  <= 1'b0;
					mem_we   <= 1'b0;
					wcnt_reg <= 3'h0;
					if (cap_op_reg == OP_DWBINV) begin
						rsp_valid <= 1'b1;
						pend_reg  <= 1'b0;
						core_busy <= 1'b0;
						state_reg <= ST_IDLE;
					end else begin
						state_reg <= ST_FILL;
					end
				end
			end
			ST_FILL: begin
				if (launch) begin                          // RULE11
					mem_req  <= 1'b1;
					mem_we   <= 1'b0;
					mem_addr <= fill_addr;
					mem_apar <= scc_bpar(fill_addr);
					wcnt_reg <= wcnt_reg + 3'h1;
				end else if (last_ack) begin
					// whole line present: replay the request
					mem_req   <= 1'b0;
					wcnt_reg  <= 3'h0;
					state_reg <= ST_IDLE;
				end
			end
			default: state_reg <= ST_IDLE;
			endcase
		end
	end

	// ------------------------------------------------------------------
	// store pipeline: check stage is the lookup, this is the write stage
	// ------------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			st_v_reg   <= 1'b0;
			st_idx_reg <= 6'h00;
			st_w_reg   <= 2'h0;
			st_d_reg   <= 32'h0000_0000;
			st_be_reg  <= 4'h0;
		end else begin
			st_v_reg <= act && (c_op == OP_STORE) && d_hit;   // RULE2
			if (act && (c_op == OP_STORE)) begin
				st_idx_reg <= d_idx;
				st_w_reg   <= wsel;
				st_d_reg   <= c_wd;
				st_be_reg  <= c_be;
			end
		end
	end

	// ------------------------------------------------------------------
	// array updates: store, refill, invalidate
	// ------------------------------------------------------------------
	always_ff @(posedge pclk) begin
		if (st_v_reg) begin
			for (int b = 0; b < 4; b++) begin
				if (st_be_reg[b]) begin
					ddata_mem[st_idx_reg][st_w_reg][b*8 +: 8] <=
						st_d_reg[b*8 +: 8];
					dpar_mem[st_idx_reg][st_w_reg][b] <=
						ctrl_reg[`SCC_CTRL_INJECT] ? perr_reg[b] :
						^st_d_reg[b*8 +: 8];               // RULE23
				end
			end
			// first write dirties the line; later ones change nothing
			dtag_mem[st_idx_reg][`SCC_TAG_DIRTY] <= 1'b1;    // RULE14 RULE15
			dtag_mem[st_idx_reg][`SCC_TAG_DPAR]  <= 1'b1;    // RULE8
		end
		if ((state_reg == ST_FILL) && mem_ack) begin
			if (cap_is_i) begin
				idata_mem[cap_iidx][fw] <= mem_rdata;
				ipar_mem[cap_iidx][fw]  <=
					ctrl_reg[`SCC_CTRL_INJECT] ? perr_reg[0] :
					^mem_rdata;                            // RULE6 RULE23
			end else begin
				ddata_mem[cap_didx][fw] <= mem_rdata;
				dpar_mem[cap_didx][fw]  <= mem_rpar;
			end
		end
		// refill installs a valid clean line
		if ((state_reg == ST_FILL) && last_ack) begin
			if (cap_is_i)
				itag_mem[cap_iidx] <= {^cap_pa_reg[31:10], 1'b1,
				                       cap_pa_reg[31:10]}; // RULE5 RULE15
			else
				dtag_mem[cap_didx] <= {2'b00, ^cap_pa_reg[31:10], 1'b1,
				                       cap_pa_reg[31:10]}; // RULE8 RULE15
		end
		// written-back line keeps no copy
		if ((state_reg == ST_WB) && last_ack &&
		    (cap_op_reg == OP_DWBINV))
			dtag_mem[cap_didx][`SCC_TAG_VALID] <= 1'b0;      // RULE13
		if (act && (c_op == OP_IINV) && !i_tperr)
			itag_mem[i_idx][`SCC_TAG_VALID] <= 1'b0;         // RULE14 RULE21
		if (act && (c_op == OP_DWBINV) && !d_tperr &&
		    !(dt[`SCC_TAG_VALID] && d_dirty))
			dtag_mem[d_idx][`SCC_TAG_VALID] <= 1'b0;         // RULE14
	end

	// ------------------------------------------------------------------
	// apb slave: control registers only, arrays are not mapped
	// ------------------------------------------------------------------
	logic apb_wr;                        // write takes effect this edge

	assign apb_wr = psel && penable && pready && pwrite;

	// zero wait states; unmapped offsets flag pslverr
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)                               // RULE22
				`SCC_OFS_CTRL:  prdata <= {30'h0, ctrl_reg};
				`SCC_OFS_PERR:  prdata <= {28'h0, perr_reg};
				`SCC_OFS_FAULT: prdata <= {27'h0, fault_reg};
				`SCC_OFS_STAT:  prdata <= {27'h0, core_busy, pend_reg,
				                           state_reg};
				default: begin
					prdata  <= 32'h0000_0000;
					pslverr <= 1'b1;
				end
				endcase
			end
		end
	end

	// software-written control and injection values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ctrl_reg <= `SCC_CTRL_RST;
			perr_reg <= `SCC_PERR_RST;
		end else if (apb_wr) begin
			if (paddr == `SCC_OFS_CTRL)
				ctrl_reg <= pwdata[1:0];
			if (paddr == `SCC_OFS_PERR)
				perr_reg <= pwdata[3:0];
		end
	end

	// sticky fault sources, write one to clear; a new fault wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			fault_reg <= `SCC_FAULT_RST;
		else if (apb_wr && (paddr == `SCC_OFS_FAULT))
			fault_reg <= (fault_reg & ~pwdata[4:0]) | fault_set; // RULE17
		else
			fault_reg <= fault_reg | fault_set;                  // RULE17
	end

endmodule

// *** scc_props.sv ***
// assertion checker bound to the split cache controller
`timescale 1ns/100ps
`include "scc_regs.svh"
module scc_props (
	input logic        pclk,
	input logic        presetn,
	input logic        psel,
	input logic        penable,
	input logic        pwrite,
	input logic [7:0]  paddr,
	input logic [31:0] pwdata,
	input logic        pready,
	input logic        core_req,
	input logic        core_busy,
	input logic        rsp_valid,
	input logic        cache_err_exc,
	input logic        mem_req,
	input logic        mem_we,
	input logic        mem_ack,
	input logic [31:0] mem_addr,
	input logic [3:0]  mem_apar,
	input logic [31:0] mem_rdata,
	input logic [3:0]  mem_rpar
);
	logic trap_q; // trap-off bit as last written
	logic ctrl_wr; // completing apb write
	assign ctrl_wr = psel && penable && pready && pwrite;
	// even parity of each byte
	function automatic logic [3:0] bp(input logic [31:0] w);
		return {^w[31:24], ^w[23:16], ^w[15:8], ^w[7:0]};
	endfunction
	// ------------------------------
	// helper state and sequences
	// ------------------------------
	// mirror kept here because the register itself is not a port
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			trap_q <= 1'b0;
		else if (ctrl_wr && paddr == `SCC_OFS_CTRL)
			trap_q <= pwdata[`SCC_CTRL_TRAPOFF];
	end
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	sequence word_step;
		mem_req && mem_ack && mem_addr[3:2] != 2'h3;
	endsequence
	sequence last_fill;
		mem_req && mem_ack && !mem_we && mem_addr[3:2] == 2'h3;
	endsequence
	sequence replay_done;
		!mem_req ##[1:2] rsp_valid;
	endsequence
	ready_one_a: assert property (psel && !penable |=> pready ##1 !pready)
		else $error("apb ready not a single cycle");
	take_rsp_a:
	assert property (core_req && !core_busy |=> rsp_valid || core_busy)
		else $error("request neither answered nor stalled");
	line_start_a:
	assert property ($rose(mem_req) |-> mem_addr[3:2] == 2'h0)
		else $error("line not starting at word zero");
	line_step_a:
	assert property (word_step |=> mem_req &&
		mem_addr[3:2] == $past(mem_addr[3:2]) + 2'h1)
		else $error("line words out of order");
	fill_end_a: assert property (last_fill |=> replay_done)
		else $error("no replay after refill");
	addr_par_a: assert property (mem_req |-> mem_apar == bp(mem_addr))
		else $error("address parity wrong");
	trap_off_a: assert property (trap_q |-> !cache_err_exc)
		else $error("exception while traps off");
	mem_err_a:
	assert property (mem_req && mem_ack && !mem_we && !trap_q &&
		mem_rpar != bp(mem_rdata) |-> ##[1:3] cache_err_exc)
		else $error("memory parity error missed");
endmodule
bind scc_top scc_props u_scc_props (.*);

// *** scc_mem_model.sv ***
// behavioural main memory serving line refills and write-backs
`timescale 1ns/100ps
module scc_mem_model (
	input  logic        pclk,
	input  logic        presetn,
	input  logic        mem_req,
	input  logic        mem_we,
	input  logic [31:0] mem_addr,
	input  logic        slow,
	input  logic        bad_par,
	output logic        mem_ack,
	output logic [31:0] mem_rdata,
	output logic [3:0]  mem_rpar,
	output int          n_wr
);
	logic [1:0]  wait_q; // stall cycles on the current word
	logic [31:0] word;   // contents are a fixed image of the address
	logic        go;     // word may be answered now
	assign word = mem_addr ^ 32'hC3C3_0000;
	assign go = mem_req && !mem_ack && (!slow || wait_q == 2'h3);
	// ------------------------------
	// handshake and read data
	// ------------------------------
	// idle data toggles so a stale word never looks valid
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mem_ack   <= 1'b0;
			wait_q    <= 2'h0;
			mem_rdata <= 32'h0;
			mem_rpar  <= 4'h0;
		end else if (go) begin
			mem_ack   <= 1'b1;
			wait_q    <= 2'h0;
			mem_rdata <= word;
			mem_rpar  <= {^word[31:24], ^word[23:16], ^word[15:8],
				^word[7:0] ^ bad_par};
		end else begin
			mem_ack   <= 1'b0;
			wait_q    <= mem_req ? wait_q + 2'h1 : 2'h0;
			mem_rdata <= ~mem_rdata;
			mem_rpar  <= ~mem_rpar;
		end
	end
	// written-word count for the bench
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			n_wr <= 0;
		else if (mem_req && mem_ack)
			n_wr <= n_wr + int'(mem_we);
	end
endmodule

// *** tb_top.sv ***
// self-checking bench for the split cache controller
`timescale 1ns/100ps
`include "scc_regs.svh"
module tb_top;
	import scc_pkg::*;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
	logic        pwrite = 1'b0, core_req = 1'b0, slow = 1'b0, bad_par = 1'b0;
	logic [7:0]  paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, core_vaddr = 32'h0, core_paddr = 32'h0;
	logic [31:0] core_wdata = 32'h0;
	logic [3:0]  core_be = 4'hF; // full-word stores only
	scc_op_t     core_op = OP_LOAD;
	logic [31:0] prdata, rsp_data, mem_addr, mem_wdata, mem_rdata, rd;
	logic [3:0]  mem_apar, mem_wpar, mem_rpar;
	logic        pready, pslverr, core_busy, rsp_valid, cache_err_exc;
	logic        mem_req, mem_we, mem_ack, er;
	int          num_errors = 0, n_compared = 0, n_exc = 0;
	int          n_wr, lat, w0, e0;
	localparam logic [31:0] LA = 32'h0000_4000; // two labels, one index
	localparam logic [31:0] LB = 32'h0000_8000;
	scc_top       u_scc_top (.*);
	scc_mem_model u_scc_mem_model (.*);
	initial forever #5 pclk = ~pclk;
	// exception pulses counted
	always @(posedge pclk)
		if (cache_err_exc === 1'b1) n_exc <= n_exc + 1;
	// ------------------------------
	// shared tasks
	// ------------------------------
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_compared++;
		if (g !== e) begin
			num_errors++;
			$display("Error %0t: got %h expected %h", $time, g, e);
		end
	endtask
	function automatic logic [31:0] mw(input logic [31:0] a);
		return a ^ 32'hC3C3_0000;
	endfunction
	// request held until pready is sampled high
	task automatic apb(input logic w, input logic [7:0] a,
		input logic [31:0] d);
		int t = 0;
		@(posedge pclk);
		psel    <= 1'b1;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1 && ++t < 20);
		if (t >= 20) num_errors++;
		rd = prdata;
		er = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask
	// lat counts edges from take to completion
	task automatic core(input scc_op_t op, input logic [31:0] va,
		input logic [31:0] pa, input logic [31:0] wd);
		@(posedge pclk);
		core_req   <= 1'b1;
		core_op    <= op;
		core_vaddr <= va;
		core_paddr <= pa;
		core_wdata <= wd;
		lat = 0;
		do @(posedge pclk); while (core_busy !== 1'b0 && ++lat < 300);
		core_req <= 1'b0;
		lat = 1;
		do @(posedge pclk); while (rsp_valid !== 1'b1 && ++lat < 300);
		if (lat >= 300) num_errors++;
		rd = rsp_data;
	endtask
	task automatic end_of_test;
		$display("compared %0d errors %0d", n_compared, num_errors);
		if (num_errors == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// ------------------------------
	// scenarios
	// ------------------------------
	task automatic t_regs;
		for (int i = 0; i < 3; i++) begin
			apb(1'b0, 8'(4 * i), 32'h0);
			chk(rd, 32'h0);
		end
		apb(1'b0, `SCC_OFS_STAT, 32'h0);
		chk(rd, 32'h1);
		apb(1'b1, 8'h10, 32'hFFFF_FFFF);
		chk(32'(er), 32'h1);
		apb(1'b1, `SCC_OFS_CTRL, 32'h3);
		apb(1'b0, `SCC_OFS_CTRL, 32'h0);
		chk(rd, 32'h3);
		apb(1'b1, `SCC_OFS_CTRL, 32'h0);
		$display("t_regs done");
	endtask
	task automatic t_dcache;
		core(OP_DWBINV, 32'h10, LA, 32'h0);
		w0 = n_wr;
		core(OP_LOAD, 32'h14, LA + 32'h14, 32'h0);
		chk(rd, mw(LA + 32'h14));
		chk(32'(n_wr - w0), 32'h0);
		core(OP_LOAD, 32'h414, LA + 32'h14, 32'h0);
		chk(32'(lat), 32'h1);
		core(OP_STORE, 32'h18, LA + 32'h18, 32'h1234_5678);
		chk(32'(lat), 32'h1);
		core(OP_LOAD, 32'h18, LA + 32'h18, 32'h0);
		chk(rd, 32'h1234_5678);
		w0 = n_wr;
		core(OP_LOAD, 32'h14, LB + 32'h14, 32'h0);
		chk(32'(n_wr - w0), 32'h4);
		chk(rd, mw(LB + 32'h14));
		core(OP_STORE, 32'h14, LB + 32'h14, 32'h0);
		w0 = n_wr;
		core(OP_DWBINV, 32'h10, 32'h0, 32'h0);
		chk(32'(n_wr - w0), 32'h4);
		w0 = n_wr;
		core(OP_LOAD, 32'h14, LB + 32'h14, 32'h0);
		chk(32'(lat > 1), 32'h1);
		chk(32'(n_wr - w0), 32'h0);
		$display("t_dcache done");
	endtask
	task automatic t_ifetch;
		slow <= 1'b1;
		core(OP_IINV, 32'h20, 32'h0, 32'h0);
		core(OP_IINV, 32'h420, 32'h0, 32'h0);
		core(OP_IFETCH, 32'h24, LA + 32'h24, 32'h0);
		chk(rd, mw(LA + 32'h24));
		core(OP_IFETCH, 32'h24, LA + 32'h24, 32'h0);
		chk(32'(lat), 32'h1);
		core(OP_IFETCH, 32'h424, LA + 32'h24, 32'h0);
		chk(32'(lat > 1), 32'h1);
		slow <= 1'b0;
		$display("t_ifetch done");
	endtask
	task automatic t_parity;
		core(OP_DWBINV, 32'h30, 32'h0, 32'h0);
		e0 = n_exc;
		bad_par <= 1'b1;
		core(OP_LOAD, 32'h30, LA + 32'h30, 32'h0);
		repeat (4) @(posedge pclk);
		chk(32'(n_exc > e0), 32'h1);
		apb(1'b0, `SCC_OFS_FAULT, 32'h0);
		chk(32'(rd[`SCC_FLT_MEM]), 32'h1);
		apb(1'b1, `SCC_OFS_FAULT, 32'h1F);
		apb(1'b1, `SCC_OFS_CTRL, 32'h2);
		core(OP_DWBINV, 32'h40, 32'h0, 32'h0);
		e0 = n_exc;
		core(OP_LOAD, 32'h40, LA + 32'h40, 32'h0);
		repeat (4) @(posedge pclk);
		chk(32'(n_exc - e0), 32'h0);
		apb(1'b0, `SCC_OFS_FAULT, 32'h0);
		chk(32'(rd[`SCC_FLT_MEM]), 32'h1);
		bad_par <= 1'b0;
		$display("t_parity done");
	endtask
	initial begin
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		t_regs;
		t_dcache;
		t_ifetch;
		t_parity;
		end_of_test;
	end
	// watchdog: the run needs a few hundred cycles
	initial begin
		#200000;
		num_errors++;
		end_of_test;
	end
endmodule
